// *** rtl/khm_map.vh ***
/*
  Constants for the host keyboard mailbox: host I/O addresses, status
  field positions, reset values and pin drive timing.
  Assumes inclusion by bare name from the mailbox module.
*/
`ifndef KHM_MAP_VH
`define KHM_MAP_VH

// ----------------------------------------------------------------------
// Host I/O addresses
// ----------------------------------------------------------------------
`define KHM_ADDR_DATA      16'h0060
`define KHM_ADDR_CMD       16'h0064
`define KHM_ADDR_SEL_BIT   2

// ----------------------------------------------------------------------
// Status field positions and reset values
// ----------------------------------------------------------------------
`define KHM_ST_OUT_FULL    0
`define KHM_ST_IN_FULL     1
`define KHM_ST_CD          3
`define KHM_ST_UD_MASK     8'hF4
`define KHM_STATUS_RST     8'h00
`define KHM_BYTE_RST       8'h00

// ----------------------------------------------------------------------
// Port 2 field positions
// ----------------------------------------------------------------------
`define KHM_P2_A20         1
`define KHM_P2_KEYBOARD_INTERRUPT_OUT        4
`define KHM_P2_MOUSE_INTERRUPT_OUT        5

// ----------------------------------------------------------------------
// Quasi-bidirectional high drive time
// ----------------------------------------------------------------------
`define KHM_CLK_PERIOD_PS  8000
`define KHM_QB_PULSE_NS    500
`define KHM_QB_CYCLES      ((`KHM_QB_PULSE_NS * 1000) / `KHM_CLK_PERIOD_PS)
`define KHM_QB_CNT_W       7

`endif

// *** rtl/khm_mailbox.v ***
/*
  Host keyboard mailbox: host I/O port pair, processor data buffer,
  status flags, keyboard and mouse interrupt outputs, gate A20 and three
  quasi-bidirectional port pins.
  Assumes host strobes are one-cycle pulses on ref_clk_i and that
  processor strobes are likewise; port 2 and pin values are levels
  from logic on ref_clk_i, while the quasi pin inputs come from pads
  and are synchronised before use. Pad buffers sit outside: a pin is
  driven with quasi_pin_o while quasi_pin_oe_o is high and is held
  high by an external pull-up otherwise.
*/
`timescale 1ns/100ps
`include "khm_map.vh"

module khm_mailbox #(
  parameter QB_CYCLES = `KHM_QB_CYCLES
) (
  // Clock and reset
  input  wire        ref_clk_i,
  input  wire        arst_n_i,
  // Host I/O bus
  input  wire [15:0] host_addr_i,
  input  wire        host_wr_i,
  input  wire        host_rd_i,
  input  wire [7:0]  host_wdata_i,
  output reg  [7:0]  host_rdata_o,
  output wire        host_ack_o,
  // Embedded processor side
  input  wire        proc_buf_wr_i,
  input  wire [7:0]  proc_buf_wdata_i,
  input  wire        proc_buf_rd_i,
  output reg  [7:0]  proc_buf_rdata_o,
  input  wire        proc_status_wr_i,
  input  wire [7:0]  proc_status_wdata_i,
  output wire [7:0]  proc_status_o,
  input  wire        proc_en_flags_i,
  input  wire        proc_out_full_clr_i,
  input  wire [7:0]  proc_port2_i,
  input  wire [2:0]  proc_quasi_val_i,
  input  wire        proc_open_drain_i,
  output wire [2:0]  proc_quasi_pin_o,
  output wire        proc_in_full_irq_o,
  // Interrupt and gate outputs
  output reg         keyboard_interrupt_out_o,
  output reg         mouse_interrupt_out_o,
  output reg         gate_a20_o,
  // Quasi-bidirectional pins: c, b, a
  input  wire [2:0]  quasi_pin_i,
  output reg  [2:0]  quasi_pin_o,
  output reg  [2:0]  quasi_pin_oe_o
);

  // --------------------------------------------------------------------
  // Host decode
  // --------------------------------------------------------------------
  // Exact match of a host I/O address
  function khm_addr_is;
    input [15:0] addr;
    input [15:0] port;
    begin
      khm_addr_is = (addr == port);
    end
  endfunction

  // Data port and command/status port hits
  wire hit_data = khm_addr_is(host_addr_i, `KHM_ADDR_DATA);
  wire hit_cmd  = khm_addr_is(host_addr_i, `KHM_ADDR_CMD);
  wire host_hit = hit_data | hit_cmd;

  // Qualified strobes; unmapped addresses do nothing
  wire host_wr   = host_wr_i & host_hit;
  wire host_rd_d = host_rd_i & hit_data;
  wire host_rd_s = host_rd_i & hit_cmd;

  // Handshake, combinational in the strobe cycle
  assign host_ack_o = (host_wr_i | host_rd_i) & host_hit;

  // --------------------------------------------------------------------
  // Mailbox registers
  // --------------------------------------------------------------------
  reg  [7:0] in_byte_reg;
  reg  [7:0] out_byte_reg;
  reg  [7:0] ud_bits_reg;
  reg        cd_reg;
  reg        in_full_reg;
  reg        out_full_reg;
  reg        en_flags_reg;
  wire [7:0] status_word;

  // Port 2 fields used by the host side
  wire kb_irq_port_bit    = proc_port2_i[`KHM_P2_KEYBOARD_INTERRUPT_OUT];
  wire mouse_irq_port_bit = proc_port2_i[`KHM_P2_MOUSE_INTERRUPT_OUT];
  wire gate_a20_port_bit  = proc_port2_i[`KHM_P2_A20];

  wire in_full  = in_full_reg;
  wire out_full = out_full_reg;

  // Status image: user bits, C/D, in-full, out-full
  assign status_word = (ud_bits_reg & `KHM_ST_UD_MASK) |
                       ({7'h00, cd_reg} << `KHM_ST_CD) |
                       ({7'h00, in_full_reg} << `KHM_ST_IN_FULL) |
                       ({7'h00, out_full_reg} << `KHM_ST_OUT_FULL);

  assign proc_status_o      = status_word;
  assign proc_in_full_irq_o = in_full;

  // Input byte, overwritten on every host write
  always @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      in_byte_reg <= `KHM_BYTE_RST;
    end else if (host_wr) begin
      in_byte_reg <= host_wdata_i;
    end
  end

  // Output byte loaded by processor buffer write
  always @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      out_byte_reg <= `KHM_BYTE_RST;
    end else if (proc_buf_wr_i) begin
      out_byte_reg <= proc_buf_wdata_i;
    end
  end

  // Flag mode latch, sticky once executed
  always @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      en_flags_reg <= 1'b0;
    end else if (proc_en_flags_i) begin
      en_flags_reg <= 1'b1;
    end
  end

  // User bits, writable by the processor only
  always @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ud_bits_reg <= `KHM_STATUS_RST;
    end else if (proc_status_wr_i) begin
      ud_bits_reg <= proc_status_wdata_i & `KHM_ST_UD_MASK;
    end
  end

  // C/D copies host address bit 2 on each write
  always @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cd_reg <= 1'b0;
    end else if (host_wr) begin
      cd_reg <= host_addr_i[`KHM_ADDR_SEL_BIT];
    end
  end

  // In-full: host write set wins over processor read clear
  always @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      in_full_reg <= 1'b0;
    end else if (host_wr) begin
      in_full_reg <= 1'b1;
    end else if (proc_buf_rd_i) begin
      in_full_reg <= 1'b0;
    end
  end

  // Out-full: processor write set wins over any clear
  always @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      out_full_reg <= 1'b0;
    end else if (proc_buf_wr_i) begin
      out_full_reg <= 1'b1;
    end else if ((host_rd_d && en_flags_reg) || proc_out_full_clr_i) begin
      out_full_reg <= 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // Read data
  // --------------------------------------------------------------------
  // Host read mux; status port is read only
  always @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      host_rdata_o <= `KHM_BYTE_RST;
    end else if (host_rd_d) begin
      host_rdata_o <= out_byte_reg;
    end else if (host_rd_s) begin
      host_rdata_o <= status_word;
    end
  end

  // Processor read of input byte
  always @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      proc_buf_rdata_o <= `KHM_BYTE_RST;
    end else if (proc_buf_rd_i) begin
      proc_buf_rdata_o <= in_byte_reg;
    end
  end

  // --------------------------------------------------------------------
  // Interrupt and gate outputs
  // --------------------------------------------------------------------
  // Keyboard irq: gated out-full in flag mode, else port bit
  always @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      keyboard_interrupt_out_o <= 1'b0;
    end else if (en_flags_reg) begin
      keyboard_interrupt_out_o <= kb_irq_port_bit & out_full;
    end else begin
      keyboard_interrupt_out_o <= kb_irq_port_bit;
    end
  end

  // Mouse irq: gated inverted in-full in flag mode, else port bit
  always @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mouse_interrupt_out_o <= 1'b0;
    end else if (en_flags_reg) begin
      mouse_interrupt_out_o <= mouse_irq_port_bit & ~in_full;
    end else begin
      mouse_interrupt_out_o <= mouse_irq_port_bit;
    end
  end

  // Gate A20 straight from its port bit
  always @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      gate_a20_o <= 1'b0;
    end else begin
      gate_a20_o <= gate_a20_port_bit;
    end
  end

  // --------------------------------------------------------------------
  // Quasi-bidirectional pins
  // --------------------------------------------------------------------
  // Number of quasi-bidirectional pins
  localparam QB_PINS = 3;

  reg  [2:0] pin_meta_reg;
  reg  [2:0] pin_sync_reg;
  reg  [2:0] val_prev_reg;
  reg  [`KHM_QB_CNT_W-1:0] pulse_cnt_reg [0:QB_PINS-1];

  assign proc_quasi_pin_o = pin_sync_reg;

  // Pin level synchroniser for processor reads
  always @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_meta_reg <= 3'h0;
      pin_sync_reg <= 3'h0;
    end else begin
      pin_meta_reg <= quasi_pin_i;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // Per pin drive; released for input after the high pulse or in open drain, never inverted
  genvar g;
  generate
    for (g = 0; g < QB_PINS; g = g + 1) begin : g_qb
      always @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          val_prev_reg[g]   <= 1'b0;
          pulse_cnt_reg[g]  <= {`KHM_QB_CNT_W{1'b0}};
          quasi_pin_o[g]    <= 1'b0;
          quasi_pin_oe_o[g] <= 1'b1;
        end else begin
          val_prev_reg[g] <= proc_quasi_val_i[g];
          if (!proc_quasi_val_i[g]) begin
            quasi_pin_o[g]    <= 1'b0;
            quasi_pin_oe_o[g] <= 1'b1;
            pulse_cnt_reg[g]  <= {`KHM_QB_CNT_W{1'b0}};
          end else if (proc_open_drain_i) begin
            quasi_pin_o[g]    <= 1'b0;
            quasi_pin_oe_o[g] <= 1'b0;
          end else if (!val_prev_reg[g]) begin
            quasi_pin_o[g]    <= 1'b1;
            quasi_pin_oe_o[g] <= 1'b1;
            pulse_cnt_reg[g]  <= QB_CYCLES[`KHM_QB_CNT_W-1:0] - 7'h01;
          end else if (pulse_cnt_reg[g] != {`KHM_QB_CNT_W{1'b0}}) begin
            pulse_cnt_reg[g]  <= pulse_cnt_reg[g] - 7'h01;
          end else begin
            quasi_pin_o[g]    <= 1'b0;
            quasi_pin_oe_o[g] <= 1'b0;
          end
        end
      end
    end
  endgenerate

endmodule // khm_mailbox

// *** sim/khm_mailbox_asserts.sv ***
/* Checker for the host keyboard mailbox: flags, interrupt outputs, pins.
   Bound to khm_mailbox; sees only its ports. */
`timescale 1ns/100ps
module khm_mailbox_asserts (
  // Clock, reset and inputs
  input wire        ref_clk_i,
  input wire        arst_n_i,
  input wire [15:0] host_addr_i,
  input wire        host_wr_i,
  input wire        host_rd_i,
  input wire        proc_buf_wr_i,
  input wire        proc_buf_rd_i,
  input wire        proc_en_flags_i,
  input wire [7:0]  proc_port2_i,
  input wire [2:0]  proc_quasi_val_i,
  input wire        proc_open_drain_i,
  // Outputs watched
  input wire [7:0]  proc_status_o,
  input wire        keyboard_interrupt_out_o,
  input wire        mouse_interrupt_out_o,
  input wire [2:0]  quasi_pin_o,
  input wire [2:0]  quasi_pin_oe_o
);
  reg  flag_mode_reg;
  wire wr_d = host_wr_i && host_addr_i == 16'h0060;
  wire wr_c = host_wr_i && host_addr_i == 16'h0064;
  wire rd_d = host_rd_i && host_addr_i == 16'h0060;
  wire dir  = !flag_mode_reg && !proc_en_flags_i;
  // Flag mode seen so far
  always @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i)
      flag_mode_reg <= 1'b0;
    else if (proc_en_flags_i)
      flag_mode_reg <= 1'b1;
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);
  // Output flag drops, then keyboard irq follows
  sequence out_full_kb_irq_low_s;
    !proc_status_o[0] ##1 !keyboard_interrupt_out_o;
  endsequence
  AST_DATA_WR: assert property (wr_d |=> proc_status_o[1] && !proc_status_o[3])
    else $error("data write flags wrong");
  AST_CMD_WR: assert property (wr_c |=> proc_status_o[1] && proc_status_o[3])
    else $error("command write flags wrong");
  AST_OUTF_SET: assert property (proc_buf_wr_i |=> proc_status_o[0])
    else $error("output flag not set");
  AST_INF_CLR: assert property (proc_buf_rd_i && !host_wr_i |=> !proc_status_o[1])
    else $error("input flag not cleared");
  AST_RD_CLR: assert property (flag_mode_reg && rd_d && !proc_buf_wr_i |=> out_full_kb_irq_low_s)
    else $error("host read did not clear");
  AST_KB_IRQ_RST: assert property ($rose(arst_n_i) |-> !keyboard_interrupt_out_o)
    else $error("keyboard irq high after reset");
  AST_KB_IRQ_DIR: assert property (dir |=> keyboard_interrupt_out_o == $past(proc_port2_i[4]))
    else $error("keyboard irq not port bit");
  AST_KB_IRQ_FLAG: assert property (flag_mode_reg |=> keyboard_interrupt_out_o == ($past(proc_port2_i[4]) && $past(proc_status_o[0])))
    else $error("keyboard irq not gated output flag");
  AST_MS_IRQ_FLAG: assert property (flag_mode_reg && proc_port2_i[5] |=> mouse_interrupt_out_o == !$past(proc_status_o[1]))
    else $error("mouse irq not inverted input flag");
  AST_OD_REL: assert property (proc_open_drain_i && proc_quasi_val_i[1] |=> !quasi_pin_oe_o[1])
    else $error("open drain pin driven");
  AST_PIN_LOW: assert property (!proc_quasi_val_i[2] |=> quasi_pin_oe_o[2] && !quasi_pin_o[2])
    else $error("pin not driven low");
endmodule // khm_mailbox_asserts

bind khm_mailbox khm_mailbox_asserts chk_u (.ref_clk_i, .arst_n_i, .host_addr_i, .host_wr_i, .host_rd_i,
  .proc_buf_wr_i, .proc_buf_rd_i, .proc_en_flags_i, .proc_port2_i, .proc_quasi_val_i, .proc_open_drain_i,
  .proc_status_o, .keyboard_interrupt_out_o, .mouse_interrupt_out_o, .quasi_pin_o, .quasi_pin_oe_o);

// *** sim/khm_host_model.sv ***
/* Host CPU model: one-cycle I/O read and write strobes.
   Assumes the mailbox samples on the rising clock edge. */
`timescale 1ns/100ps
module khm_host_model (
  // Clock and answer
  input  wire        ref_clk_i,
  input  wire [7:0]  host_rdata_i,
  // Host bus drive
  output reg  [15:0] host_addr_o,
  output reg         host_wr_o,
  output reg         host_rd_o,
  output reg  [7:0]  host_wdata_o
);
  // Idle bus at start
  initial begin
    host_addr_o  = 16'h0000;
    host_wr_o    = 1'b0;
    host_rd_o    = 1'b0;
    host_wdata_o = 8'h00;
  end
  // One I/O cycle; bus parked inverted after release
  task io(input w, input [15:0] a, input [7:0] d, output [7:0] q);
    begin
      @(negedge ref_clk_i);
      host_addr_o  = a;
      host_wdata_o = d;
      host_wr_o    = w;
      host_rd_o    = !w;
      @(negedge ref_clk_i);
      host_wr_o    = 1'b0;
      host_rd_o    = 1'b0;
      host_addr_o  = ~a;
      host_wdata_o = ~d;
      q            = host_rdata_i;
    end
  endtask
endmodule // khm_host_model

// *** sim/tb.sv ***
/* Mailbox bench: host cycles through the host model, processor side
   and pull-up pins driven here. Assumes a 125 MHz clock. */
`timescale 1ns/100ps
module tb;
  reg         clk = 1'b0;
  reg         rst_n = 1'b0;
  reg  [4:0]  ps = 5'h00; // buf wr, buf rd, status wr, flags, out-full clr
  reg  [7:0]  pd = 8'h00;
  reg  [7:0]  p2 = 8'h00;
  reg  [2:0]  qv = 3'h0;
  reg         od = 1'b0;
  reg  [7:0]  q;
  integer     errors = 0;
  integer     samples_checked = 0;
  integer     acks = 0;
  wire [15:0] ha;
  wire        hw, hr, kb_irq, ms_irq, a20, ack, in_irq;
  wire [7:0]  hd, hq, pq, st;
  wire [2:0]  qo, qoe, pqp;
  wire [2:0]  pin = (qoe & qo) | ~qoe; // Pull-up when released
  // Clock
  always #4 clk = ~clk;
  // Count acknowledged host cycles
  always @(posedge clk) if (ack === 1'b1) acks <= acks + 1;
  khm_host_model host_u (.ref_clk_i(clk), .host_rdata_i(hq), .host_addr_o(ha), .host_wr_o(hw),
    .host_rd_o(hr), .host_wdata_o(hd));
  khm_mailbox #(.QB_CYCLES(4)) dut_u (.ref_clk_i(clk), .arst_n_i(rst_n), .host_addr_i(ha),
    .host_wr_i(hw), .host_rd_i(hr), .host_wdata_i(hd), .host_rdata_o(hq), .host_ack_o(ack),
    .proc_buf_wr_i(ps[0]), .proc_buf_wdata_i(pd), .proc_buf_rd_i(ps[1]), .proc_buf_rdata_o(pq),
    .proc_status_wr_i(ps[2]), .proc_status_wdata_i(pd), .proc_status_o(st),
    .proc_en_flags_i(ps[3]), .proc_out_full_clr_i(ps[4]), .proc_port2_i(p2), .proc_quasi_val_i(qv),
    .proc_open_drain_i(od), .proc_quasi_pin_o(pqp), .proc_in_full_irq_o(in_irq),
    .keyboard_interrupt_out_o(kb_irq), .mouse_interrupt_out_o(ms_irq), .gate_a20_o(a20),
    .quasi_pin_i(pin), .quasi_pin_o(qo), .quasi_pin_oe_o(qoe));
  task chk(input [63:0] n, input [7:0] e, input [7:0] g);
    begin
      samples_checked = samples_checked + 1;
      if (g !== e) begin
        errors = errors + 1;
        $display("[ERR] %0s exp %h got %h", n, e, g);
      end
    end
  endtask
  task cyc;
    @(negedge clk);
  endtask
  // Processor strobe pulse
  task pr(input [4:0] k, input [7:0] d);
    begin
      @(negedge clk);
      ps = k;
      pd = d;
      @(negedge clk);
      ps = 5'h00;
    end
  endtask
  task finish_test;
    begin
      $display("checks %0d errors %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  // Watchdog
  initial begin
    #20000;
    errors = errors + 1;
    finish_test;
  end
  // Main sequence
  initial begin
    repeat (2) cyc;
    rst_n = 1'b1;
    cyc;
    chk("st", 8'h00, st);
    chk("kb_irq", 8'h00, kb_irq);
    chk("oe", 8'h07, qoe);
    p2 = 8'h32;
    cyc;
    chk("irqs", 8'h07, {kb_irq, ms_irq, a20});
    p2 = 8'h00;
    cyc;
    chk("irqs", 8'h00, {kb_irq, ms_irq, a20});
    host_u.io(1'b1, 16'h0064, 8'h11, q);
    host_u.io(1'b1, 16'h0060, 8'h22, q);
    chk("st", 8'h02, st);
    chk("in_irq", 8'h01, in_irq);
    pr(5'h02, 8'h00);
    chk("buf", 8'h22, pq);
    chk("st", 8'h00, st);
    chk("in_irq", 8'h00, in_irq);
    host_u.io(1'b1, 16'h0064, 8'hA5, q);
    chk("st", 8'h0A, st);
    host_u.io(1'b1, 16'h0061, 8'h00, q);
    chk("st", 8'h0A, st);
    pr(5'h04, 8'hFF);
    chk("st", 8'hFE, st);
    host_u.io(1'b0, 16'h0064, 8'h00, q);
    chk("rdst", 8'hFE, q);
    pr(5'h02, 8'h00);
    chk("cmd", 8'hA5, pq);
    pr(5'h04, 8'h00);
    chk("st", 8'h08, st);
    pr(5'h01, 8'h3C);
    chk("st", 8'h09, st);
    host_u.io(1'b0, 16'h0060, 8'h00, q);
    chk("out", 8'h3C, q);
    chk("st", 8'h09, st);
    pr(5'h10, 8'h00);
    chk("st", 8'h08, st);
    pr(5'h08, 8'h00);
    p2 = 8'h30;
    cyc;
    chk("ms_irq", 8'h01, ms_irq);
    pr(5'h01, 8'h77);
    cyc;
    chk("kb_irq", 8'h01, kb_irq);
    host_u.io(1'b0, 16'h0060, 8'h00, q);
    cyc;
    chk("out", 8'h77, q);
    chk("st", 8'h08, st);
    chk("kb_irq", 8'h00, kb_irq);
    host_u.io(1'b1, 16'h0060, 8'h01, q);
    cyc;
    chk("ms_irq", 8'h00, ms_irq);
    pr(5'h02, 8'h00);
    cyc;
    chk("ms_irq", 8'h01, ms_irq);
    p2 = 8'h20;
    pr(5'h01, 8'h55);
    cyc;
    chk("kb_irq", 8'h00, kb_irq);
    qv = 3'h1;
    cyc;
    chk("oe", 8'h07, qoe);
    chk("pin", 8'h01, pin);
    repeat (6) cyc;
    chk("oe", 8'h06, qoe);
    chk("pin", 8'h01, pin);
    chk("qpin", 8'h01, pqp);
    od = 1'b1;
    qv = 3'h3;
    cyc;
    chk("oe", 8'h04, qoe);
    chk("pin", 8'h03, pin);
    qv = 3'h0;
    cyc;
    chk("oe", 8'h07, qoe);
    chk("acks", 8'h07, acks[7:0]);
    finish_test;
  end
endmodule // tb
